// >>> common/tws_regs.svh
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

// Clock of both ends
`define TWS_MCLK_MHZ          100
`define TWS_MCLK_PERIOD_NS    10

// Word framing
`define TWS_WORD_BITS         8
`define TWS_ACK_BIT           4'd8
`define TWS_LAST_DATA_BIT     4'd7
`define TWS_RW_BIT            0
`define TWS_RECOVER_LAST      4'd8

// Internal write time, longest figures
`define TWS_IWT_ROOM_MS       5
`define TWS_IWT_FULL_MS       7
`define TWS_IWT_ROOM_CYC      (`TWS_IWT_ROOM_MS * 1000 * `TWS_MCLK_MHZ)
`define TWS_IWT_FULL_CYC      (`TWS_IWT_FULL_MS * 1000 * `TWS_MCLK_MHZ)
`define TWS_TIMER_W           20

// Serial clock, shortest period split in quarters
`define TWS_SCL_MIN_PERIOD_NS 1000
`define TWS_SCL_QTR_CYC       ((`TWS_SCL_MIN_PERIOD_NS + 4 * `TWS_MCLK_PERIOD_NS - 1) / (4 * `TWS_MCLK_PERIOD_NS))
`define TWS_QTR_W             8

// Reset values and FIFO depth
`define TWS_LINE_IDLE         1'b1
`define TWS_FIFO_DEPTH        16

`endif

// >>> common/tws_pkg.sv
`include "tws_regs.svh"

package tws_pkg;

	typedef logic [`TWS_WORD_BITS-1:0] tws_word_type;
	typedef logic [`TWS_TIMER_W-1:0]   tws_timer_type;

	typedef enum logic [2:0] {
		DEV_IDLE, DEV_RECV, DEV_ACK, DEV_SEND, DEV_MACK, DEV_WRITE
	} tws_dev_state_type;

	typedef struct packed {
		tws_dev_state_type state;
		logic              sclPrev;
		logic              sdaPrev;
		logic [3:0]        bitCnt;
		tws_word_type      shift;
		logic              firstWord;
		logic              readMode;
		logic              wroteData;
		logic              hostAck;
		logic              nSdaOe;
		logic              sdaOut;
		tws_word_type      rxData;
		logic              rxValid;
		logic              rxFirst;
		logic              readTake;
		logic              standby;
		logic              writeBusy;
		logic              frameError;
		tws_timer_type     timer;
	} tws_dev_reg_type;

	typedef enum logic [2:0] {
		HST_RECOVER, HST_IDLE, HST_START, HST_SEND, HST_RECV, HST_STOP, HST_WAIT
	} tws_host_state_type;

	typedef struct packed {
		tws_host_state_type state;
		logic [1:0]         phase;
		logic [`TWS_QTR_W-1:0] qCnt;
		logic [3:0]         bitCnt;
		logic [3:0]         recCnt;
		tws_word_type       shift;
		tws_word_type       remain;
		logic               isRead;
		logic               sentCmd;
		logic               wrote;
		logic               ackBad;
		logic               pop;
		logic               scl;
		logic               nSdaOe;
		logic               sdaOut;
		tws_word_type       rdData;
		logic               rdValid;
		logic               busy;
		logic               nack;
		tws_timer_type      timer;
	} tws_host_reg_type;

endpackage

// >>> common/tws_link_if.sv
`timescale 1ns/1ps

interface tws_link_if;
	logic scl;
	logic hostSdaOut;
	logic nHostSdaOe;
	logic devSdaOut;
	logic nDevSdaOe;
	logic sda;

	// Wired-AND with pull-up: a party pulls low only while its enable is low
	assign sda = (nHostSdaOe | hostSdaOut) & (nDevSdaOe | devSdaOut);

	modport target (
		input  scl,
		input  sda,
		output devSdaOut,
		output nDevSdaOe
	);

	modport master (
		output scl,
		output hostSdaOut,
		output nHostSdaOe,
		input  sda
	);
endinterface // tws_link_if

// >>> logic/tws_target.sv
`timescale 1ns/1ps
`include "tws_regs.svh"

// Behaviour
// [R1] Data changes only while clock low
// [R2] Falling data, clock high, opens command
// [R3] Rising data, clock high, ends sequence
// [R4] Stop after read enters standby
// [R5] Words are eight clocked bits
// [R6] Target pulls data low on ninth clock
// [R7] Master recovers bus, then issues start; the master here follows that start with one clock and a stop
// [R8] Stop after write starts timed write
// [R9] Sample on rising, update on falling
// [R10] Target drives data low only
// [R11] Release line after ninth falling edge
module tws_target #(
	parameter int unsigned WRITE_CYC = `TWS_IWT_ROOM_CYC
) (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	// Two-wire link
	tws_link_if.target                 link,
	// Received words
	output      tws_pkg::tws_word_type rxData,
	output      logic                  rxValid,
	output      logic                  rxFirst,
	// Read data source
	input  wire tws_pkg::tws_word_type readData,
	output      logic                  readTake,
	// Status
	output      logic                  standby,
	output      logic                  writeBusy,
	output      logic                  frameError
);
	import tws_pkg::*;

	if (WRITE_CYC < 1 || WRITE_CYC >= (1 << `TWS_TIMER_W)) begin : gBadWriteCyc
		$error("WRITE_CYC does not fit the write timer");
	end

	localparam tws_dev_reg_type DEV_RESET = '{
		state:      DEV_IDLE,
		sclPrev:    `TWS_LINE_IDLE,
		sdaPrev:    `TWS_LINE_IDLE,
		bitCnt:     4'h0,
		shift:      8'h00,
		firstWord:  1'b0,
		readMode:   1'b0,
		wroteData:  1'b0,
		hostAck:    1'b0,
		nSdaOe:     1'b1,
		sdaOut:     1'b0,
		rxData:     8'h00,
		rxValid:    1'b0,
		rxFirst:    1'b0,
		readTake:   1'b0,
		standby:    1'b1,
		writeBusy:  1'b0,
		frameError: 1'b0,
		timer:      20'h0_0000
	};

	tws_dev_reg_type s;
	tws_dev_reg_type next_s;

	logic sclNow;
	logic sdaNow;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	// Data edge while clock stays high
	function automatic logic busCond(input logic sclP, input logic scl, input logic sdaP, input logic sda,
	                                 input logic rising);
		busCond = sclP & scl & (sdaP != sda) & (sda == rising);
	endfunction

	assign sclNow    = link.scl;
	assign sdaNow    = link.sda;
	assign sclRise   = ~s.sclPrev & sclNow;
	assign sclFall   = s.sclPrev & ~sclNow;
	// [R2] start detection
	assign startCond = busCond(s.sclPrev, sclNow, s.sdaPrev, sdaNow, 1'b0);
	// [R3] stop detection
	assign stopCond  = busCond(s.sclPrev, sclNow, s.sdaPrev, sdaNow, 1'b1);

	always_comb begin
		next_s            = s;
		next_s.sclPrev    = sclNow;
		next_s.sdaPrev    = sdaNow;
		next_s.rxValid    = 1'b0;
		next_s.rxFirst    = 1'b0;
		next_s.readTake   = 1'b0;
		next_s.frameError = 1'b0;
		if (s.state == DEV_WRITE) begin
			// [R8] timed write, bus ignored
			next_s.timer = s.timer - 1'b1;
			if (s.timer <= `TWS_TIMER_W'(1)) begin
				next_s.state     = DEV_IDLE;
				next_s.writeBusy = 1'b0;
				next_s.standby   = 1'b1;
			end
		end else if (startCond) begin
			// [R2] any state except DEV_WRITE restarts framing
			next_s.state     = DEV_RECV;
			next_s.bitCnt    = 4'h0;
			next_s.firstWord = 1'b1;
			next_s.readMode  = 1'b0;
			next_s.wroteData = 1'b0;
			next_s.nSdaOe    = 1'b1;
			next_s.standby   = 1'b0;
			// [R1] condition inside a word; first clock after an ack is normal
			next_s.frameError = (s.state == DEV_RECV || s.state == DEV_SEND) && s.bitCnt > 4'h1;
		end else if (stopCond) begin
			next_s.nSdaOe = 1'b1;
			// [R1] condition inside a word
			next_s.frameError = (s.state == DEV_RECV || s.state == DEV_SEND) && s.bitCnt > 4'h1;
			if (s.wroteData) begin
				// [R8] write sequence ends
				next_s.state     = DEV_WRITE;
				next_s.timer     = `TWS_TIMER_W'(WRITE_CYC);
				next_s.writeBusy = 1'b1;
				next_s.wroteData = 1'b0;
			end else begin
				// [R4] standby until next start
				next_s.state   = DEV_IDLE;
				next_s.standby = 1'b1;
			end
		end else begin
			unique case (s.state)
				DEV_IDLE, DEV_WRITE: begin
				end
				DEV_RECV: begin
					// [R9] sample on rising edge
					if (sclRise && s.bitCnt != `TWS_ACK_BIT) begin
						next_s.shift  = {s.shift[6:0], sdaNow};
						next_s.bitCnt = s.bitCnt + 4'h1;
					end
					// [R6] acknowledge on ninth clock
					if (sclFall && s.bitCnt == `TWS_ACK_BIT) begin
						next_s.nSdaOe  = 1'b0;
						next_s.state   = DEV_ACK;
						next_s.rxData  = s.shift;
						next_s.rxValid = 1'b1;
						next_s.rxFirst = s.firstWord;
					end
				end
				DEV_ACK: begin
					// [R11] release after ninth clock
					if (sclFall) begin
						next_s.nSdaOe    = 1'b1;
						next_s.bitCnt    = 4'h0;
						next_s.firstWord = 1'b0;
						if (s.firstWord && s.shift[`TWS_RW_BIT]) begin
							next_s.readMode = 1'b1;
							next_s.shift    = readData;
							next_s.readTake = 1'b1;
							// [R10] high bits leave line released
							next_s.nSdaOe   = readData[7];
							next_s.state    = DEV_SEND;
						end else begin
							next_s.wroteData = s.wroteData | ~s.firstWord;
							next_s.state     = DEV_RECV;
						end
					end
				end
				DEV_SEND: begin
					// [R5] eight clocks per word
					if (sclRise) begin
						next_s.bitCnt = s.bitCnt + 4'h1;
					end
					// [R9] update on falling edge
					if (sclFall) begin
						if (s.bitCnt == `TWS_ACK_BIT) begin
							next_s.nSdaOe = 1'b1;
							next_s.state  = DEV_MACK;
						end else begin
							next_s.nSdaOe = s.shift[6];
							next_s.shift  = {s.shift[6:0], 1'b0};
						end
					end
				end
				DEV_MACK: begin
					if (sclRise) begin
						next_s.hostAck = ~sdaNow;
					end
					if (sclFall) begin
						if (s.hostAck) begin
							next_s.shift    = readData;
							next_s.readTake = 1'b1;
							next_s.nSdaOe   = readData[7];
							next_s.bitCnt   = 4'h0;
							next_s.state    = DEV_SEND;
						end else begin
							// Master declined: wait for its stop
							next_s.state = DEV_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= DEV_RESET;
		end else begin
			s <= next_s;
		end
	end

	// [R10] open-drain: only a low is ever driven
	assign link.devSdaOut = s.sdaOut;
	assign link.nDevSdaOe = s.nSdaOe;
	assign rxData         = s.rxData;
	assign rxValid        = s.rxValid;
	assign rxFirst        = s.rxFirst;
	assign readTake       = s.readTake;
	assign standby        = s.standby;
	assign writeBusy      = s.writeBusy;
	assign frameError     = s.frameError;
endmodule // tws_target

// >>> logic/tws_master.sv
`timescale 1ns/1ps
`include "tws_regs.svh"

module tws_fifo #(
	parameter int unsigned WIDTH = `TWS_WORD_BITS,
	parameter int unsigned DEPTH = `TWS_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             nrst,
	// Fill side
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output      logic             inReady,
	// Drain side
	output      logic [WIDTH-1:0] outData,
	output      logic             outValid,
	input  wire logic             outReady
);
	import tws_pkg::*;

	localparam int unsigned AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
		$error("DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0]   count;
		logic          inReady;
		logic          outValid;
	} tws_fifo_reg_type;

	tws_fifo_reg_type s;
	tws_fifo_reg_type next_s;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pull;

	assign push = inValid & s.inReady;
	assign pull = outReady & s.outValid;

	always_comb begin
		next_s          = s;
		next_s.wrPtr    = s.wrPtr + AW'(push);
		next_s.rdPtr    = s.rdPtr + AW'(pull);
		next_s.count    = s.count + (AW + 1)'(push) - (AW + 1)'(pull);
		next_s.inReady  = next_s.count != (AW + 1)'(DEPTH);
		next_s.outValid = next_s.count != '0;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= '{wrPtr: '0, rdPtr: '0, count: '0, inReady: 1'b1, outValid: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[s.wrPtr] <= inData;
		end
	end

	assign inReady  = s.inReady;
	assign outValid = s.outValid;
	assign outData  = mem[s.rdPtr];
endmodule // tws_fifo

module tws_master #(
	parameter int unsigned QTR_CYC  = `TWS_SCL_QTR_CYC,
	parameter int unsigned WAIT_CYC = `TWS_IWT_FULL_CYC
) (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	// Two-wire link
	tws_link_if.master                 link,
	// Words to send, command word first
	input  wire tws_pkg::tws_word_type wrData,
	input  wire logic                  wrValid,
	output      logic                  wrReady,
	// Requests
	input  wire logic                  reqGo,
	input  wire logic                  reqRead,
	input  wire tws_pkg::tws_word_type reqCount,
	input  wire logic                  reqRecover,
	// Read words
	output      tws_pkg::tws_word_type rdData,
	output      logic                  rdValid,
	// Status
	output      logic                  busy,
	output      logic                  nack
);
	import tws_pkg::*;

	if (QTR_CYC < 1 || QTR_CYC >= (1 << `TWS_QTR_W) || WAIT_CYC < 1 || WAIT_CYC >= (1 << `TWS_TIMER_W))
	begin : gBadCounts
		$error("QTR_CYC or WAIT_CYC does not fit its counter");
	end

	tws_host_reg_type s;
	tws_host_reg_type next_s;
	tws_word_type     fifoData;
	logic             fifoValid;
	logic             tick;
	logic             sdaNow;

	tws_fifo #(.WIDTH(`TWS_WORD_BITS), .DEPTH(`TWS_FIFO_DEPTH)) uFifo (
		.mclk     (mclk),
		.nrst     (nrst),
		.inData   (wrData),
		.inValid  (wrValid),
		.inReady  (wrReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (s.pop)
	);

	assign tick   = s.qCnt == '0;
	assign sdaNow = link.sda;

	// Quarter phases: 0 set data, 1 clock high, 2 sample, 3 clock low
	always_comb begin
		next_s         = s;
		next_s.pop     = 1'b0;
		next_s.rdValid = 1'b0;
		next_s.qCnt    = tick ? `TWS_QTR_W'(QTR_CYC - 1) : s.qCnt - 1'b1;
		if (tick) begin
			next_s.phase = s.phase + 2'd1;
		end
		unique case (s.state)
			HST_IDLE: begin
				next_s.phase = 2'd0;
				if (reqRecover) begin
					next_s.state  = HST_RECOVER;
					next_s.recCnt = 4'h0;
					next_s.busy   = 1'b1;
				end else if (reqGo && fifoValid) begin
					next_s.state   = HST_START;
					next_s.isRead  = reqRead;
					next_s.remain  = reqCount;
					next_s.sentCmd = 1'b0;
					next_s.wrote   = 1'b0;
					next_s.nack    = 1'b0;
					next_s.busy    = 1'b1;
					next_s.qCnt    = `TWS_QTR_W'(QTR_CYC - 1);
				end
			end
			HST_RECOVER: if (tick) begin
				// [R7] clock until data seen high
				unique case (s.phase)
					2'd0: next_s.nSdaOe = 1'b1;
					2'd1: next_s.scl = 1'b1;
					2'd2: if (sdaNow || s.recCnt == `TWS_RECOVER_LAST) begin
						next_s.nSdaOe = 1'b0;
						next_s.state  = HST_STOP;
						next_s.phase  = 2'd0;
					end
					2'd3: begin
						next_s.scl    = 1'b0;
						next_s.recCnt = s.recCnt + 4'h1;
					end
				endcase
			end
			HST_START: if (tick) begin
				unique case (s.phase)
					2'd0: next_s.nSdaOe = 1'b1;
					2'd1: next_s.scl = 1'b1;
					2'd2: next_s.nSdaOe = 1'b0;
					2'd3: begin
						next_s.scl    = 1'b0;
						next_s.shift  = fifoData;
						next_s.pop    = 1'b1;
						next_s.bitCnt = 4'h0;
						next_s.state  = HST_SEND;
					end
				endcase
			end
			HST_SEND: if (tick) begin
				unique case (s.phase)
					2'd0: next_s.nSdaOe = (s.bitCnt == `TWS_ACK_BIT) | s.shift[7];
					2'd1: next_s.scl = 1'b1;
					2'd2: next_s.ackBad = sdaNow;
					2'd3: begin
						next_s.scl = 1'b0;
						if (s.bitCnt != `TWS_ACK_BIT) begin
							next_s.shift  = {s.shift[6:0], 1'b0};
							next_s.bitCnt = s.bitCnt + 4'h1;
						end else begin
							next_s.bitCnt  = 4'h0;
							next_s.sentCmd = 1'b1;
							if (s.ackBad) begin
								next_s.nack  = 1'b1;
								next_s.state = HST_STOP;
							end else if (s.isRead) begin
								next_s.state = (s.remain == '0) ? HST_STOP : HST_RECV;
							end else begin
								next_s.wrote = s.wrote | s.sentCmd;
								if (fifoValid) begin
									next_s.shift = fifoData;
									next_s.pop   = 1'b1;
								end else begin
									next_s.state = HST_STOP;
								end
							end
						end
					end
				endcase
			end
			HST_RECV: if (tick) begin
				unique case (s.phase)
					2'd0: next_s.nSdaOe = (s.bitCnt != `TWS_ACK_BIT) | (s.remain == 8'h01);
					2'd1: next_s.scl = 1'b1;
					2'd2: if (s.bitCnt != `TWS_ACK_BIT) begin
						next_s.shift = {s.shift[6:0], sdaNow};
					end
					2'd3: begin
						next_s.scl = 1'b0;
						if (s.bitCnt != `TWS_ACK_BIT) begin
							next_s.bitCnt = s.bitCnt + 4'h1;
							if (s.bitCnt == `TWS_LAST_DATA_BIT) begin
								next_s.rdData  = s.shift;
								next_s.rdValid = 1'b1;
							end
						end else begin
							next_s.bitCnt = 4'h0;
							next_s.remain = s.remain - 8'h01;
							if (s.remain == 8'h01) begin
								next_s.state = HST_STOP;
							end
						end
					end
				endcase
			end
			HST_STOP: if (tick) begin
				unique case (s.phase)
					2'd0: begin
						next_s.scl    = 1'b0;
						next_s.nSdaOe = 1'b0;
					end
					2'd1: next_s.scl = 1'b1;
					2'd2: next_s.nSdaOe = 1'b1;
					2'd3: begin
						// Allow the target its timed write
						next_s.state = s.wrote ? HST_WAIT : HST_IDLE;
						next_s.busy  = s.wrote;
						next_s.timer = `TWS_TIMER_W'(WAIT_CYC);
						next_s.wrote = 1'b0;
					end
				endcase
			end
			HST_WAIT: begin
				next_s.timer = s.timer - 1'b1;
				if (s.timer <= `TWS_TIMER_W'(1)) begin
					next_s.state = HST_IDLE;
					next_s.busy  = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= '{state: HST_RECOVER, phase: 2'd0, qCnt: '0, bitCnt: 4'h0, recCnt: 4'h0, shift: 8'h00,
			       remain: 8'h00, isRead: 1'b0, sentCmd: 1'b0, wrote: 1'b0, ackBad: 1'b0, pop: 1'b0,
			       scl: `TWS_LINE_IDLE, nSdaOe: 1'b1, sdaOut: 1'b0, rdData: 8'h00, rdValid: 1'b0,
			       busy: 1'b1, nack: 1'b0, timer: '0};
		end else begin
			s <= next_s;
		end
	end

	assign link.scl        = s.scl;
	assign link.hostSdaOut = s.sdaOut;
	assign link.nHostSdaOe = s.nSdaOe;
	assign rdData          = s.rdData;
	assign rdValid         = s.rdValid;
	assign busy            = s.busy;
	assign nack            = s.nack;
endmodule // tws_master

// >>> testbench/tws_framing_sva.sv
`timescale 1ns/1ps

module tws_framing_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Link signals
	input wire logic scl,
	input wire logic sda,
	input wire logic devSdaOut,
	input wire logic nDevSdaOe
);
	logic       sclPrev;
	logic       sdaPrev;
	logic       inFrame;
	logic       readCmd;
	logic       pastCmd;
	logic [3:0] bitCnt;
	logic       devAcks;

	// Target acks the command word and every word of a write
	assign devAcks = inFrame && !(readCmd && pastCmd);

	// Start, stop and clock rises as the target sees them
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			inFrame <= 1'b0;
			readCmd <= 1'b0;
			pastCmd <= 1'b0;
			bitCnt  <= 4'h0;
		end else begin
			sclPrev <= scl;
			sdaPrev <= sda;
			if (scl && sclPrev && sdaPrev && !sda) begin
				inFrame <= 1'b1;
				pastCmd <= 1'b0;
				bitCnt  <= 4'h0;
			end else if (scl && sclPrev && !sdaPrev && sda) begin
				inFrame <= 1'b0;
			end else if (scl && !sclPrev && inFrame) begin
				bitCnt <= (bitCnt == 4'h9) ? 4'h1 : bitCnt + 4'h1;
				if (bitCnt == 4'h9)
					pastCmd <= 1'b1;
				if (bitCnt == 4'h7 && !pastCmd)
					readCmd <= sda;
			end
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	chk_stable_clock_high: assert property (scl && sclPrev |-> $stable(nDevSdaOe))
		else $error("target enable moved while clock high");
	chk_drive_low_only: assert property (!nDevSdaOe |-> !devSdaOut)
		else $error("target drives a high level");
	chk_idle_no_drive: assert property (!inFrame |-> nDevSdaOe)
		else $error("target drives outside a frame");
	chk_ack_on_ninth: assert property ($fell(scl) && bitCnt == 4'h8 && devAcks |-> ##[1:2] !nDevSdaOe)
		else $error("no acknowledge after eighth bit");
	chk_ack_holds_low: assert property (scl && sclPrev && bitCnt == 4'h9 && devAcks |-> !sda)
		else $error("line not low in ninth clock");
	chk_ack_release: assert property ($fell(scl) && bitCnt == 4'h9 && devAcks && !readCmd |-> ##[1:2] nDevSdaOe)
		else $error("acknowledge not released");
	chk_read_no_ack: assert property (scl && sclPrev && bitCnt == 4'h9 && readCmd && pastCmd |-> nDevSdaOe)
		else $error("target drives during host acknowledge");
	chk_write_bits_free: assert property (scl && sclPrev && inFrame && bitCnt != 4'h9 && devAcks |-> nDevSdaOe)
		else $error("target drives during host data bit");
endmodule // tws_framing_sva

// >>> testbench/two_wire_serial_target_framing_tb.sv
`timescale 1ns/1ps

module two_wire_serial_target_framing_tb;
	import tws_pkg::*;
	localparam int WRC = 50;
	logic         mclk, nrst, wrValid, wrReady, reqGo, reqRead, reqRecover;
	logic         rxValid, rxFirst, readTake, standby, writeBusy, rdValid, busy, nack, rx2Valid, err2, err1;
	tws_word_type rxData, readData, wrData, reqCount, rdData, rx2Data;
	logic [8:0]   rxQ[$];
	tws_word_type rdQ[$], rx2Q[$];
	tws_word_type rdTab[4] = '{8'h96, 8'h00, 8'hFF, 8'h3C};
	int           errors = 0, n_compared = 0, wbLen, wbBad, nTake, ack2, fe2, fe1;

	tws_link_if link();
	tws_link_if link2();
	assign link2.hostSdaOut = 1'b0;

	tws_target #(.WRITE_CYC(WRC)) u_tws_target (.mclk(mclk), .nrst(nrst), .link(link), .rxData(rxData),
		.rxValid(rxValid), .rxFirst(rxFirst), .readData(readData), .readTake(readTake), .standby(standby),
		.writeBusy(writeBusy), .frameError(err1));
	tws_master #(.QTR_CYC(4), .WAIT_CYC(60)) u_tws_master (.mclk(mclk), .nrst(nrst), .link(link),
		.wrData(wrData), .wrValid(wrValid), .wrReady(wrReady), .reqGo(reqGo), .reqRead(reqRead),
		.reqCount(reqCount), .reqRecover(reqRecover), .rdData(rdData), .rdValid(rdValid), .busy(busy), .nack(nack));
	tws_target #(.WRITE_CYC(WRC)) u_tws_target_2 (.mclk(mclk), .nrst(nrst), .link(link2), .rxData(rx2Data),
		.rxValid(rx2Valid), .rxFirst(), .readData(8'h00), .readTake(), .standby(), .writeBusy(),
		.frameError(err2));
	tws_framing_sva u_tws_framing_sva (.mclk(mclk), .nrst(nrst), .scl(link.scl), .sda(link.sda),
		.devSdaOut(link.devSdaOut), .nDevSdaOe(link.nDevSdaOe));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Records what both targets and the master hand out
	always @(posedge mclk) begin
		if (rxValid) rxQ.push_back({rxFirst, rxData});
		if (rdValid) rdQ.push_back(rdData);
		if (writeBusy) wbLen++;
		if (writeBusy && standby) wbBad++;
		if (rx2Valid) rx2Q.push_back(rx2Data);
		if (!link2.nDevSdaOe) ack2++;
		if (err2) fe2++;
		if (err1) fe1++;
		if (readTake) begin
			nTake++;
			readData <= rdTab[nTake % 4];
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic clr();
		rxQ.delete();
		rdQ.delete();
		rx2Q.delete();
		wbLen = 0;
		wbBad = 0;
		nTake = 0;
		ack2 = 0;
		fe2 = 0;
		fe1 = 0;
		readData <= rdTab[0];
	endtask

	task automatic wait_idle();
		repeat (3) @(negedge mclk);
		for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(negedge mclk);
		chk(busy, 0);
		@(posedge mclk);
	endtask

	task automatic push(input tws_word_type w[$]);
		foreach (w[i]) begin
			wrData <= w[i];
			wrValid <= 1'b1;
			do @(negedge mclk); while (wrReady !== 1'b1);
			@(posedge mclk);
		end
		wrValid <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic go(input logic rd, input tws_word_type cnt);
		reqRead <= rd;
		reqCount <= cnt;
		reqGo <= 1'b1;
		@(posedge mclk);
		reqGo <= 1'b0;
		wait_idle();
	endtask

	task automatic t_write();
		clr();
		push('{8'hA2, 8'h5A, 8'hC3});
		go(1'b0, 8'h00);
		chk(rxQ.size(), 3);
		chk(rxQ[0], 9'h1A2);
		chk(rxQ[1], 9'h05A);
		chk(rxQ[2], 9'h0C3);
		chk(nack, 0);
		chk(wbLen >= WRC - 1 && wbLen <= WRC + 1, 1);
		chk(wbBad, 0);
		chk(fe1, 0);
		chk(standby, 1);
		$display("t_write done");
	endtask

	task automatic t_read();
		clr();
		push('{8'hA3});
		go(1'b1, 8'h03);
		chk(rdQ.size(), 3);
		for (int i = 0; i < 3; i++) chk(rdQ[i], rdTab[i]);
		chk(nTake, 3);
		chk(rxQ[0], 9'h1A3);
		chk(wbLen, 0);
		chk(standby, 1);
		chk(fe1, 0);
		$display("t_read done");
	endtask

	task automatic t_fifo();
		tws_word_type w[$];
		clr();
		for (int i = 0; i < 16; i++) w.push_back(8'h10 + 8'(i * 17));
		push(w);
		@(negedge mclk);
		chk(wrReady, 0);
		@(posedge mclk);
		go(1'b0, 8'h00);
		chk(rxQ.size(), 16);
		for (int i = 0; i < 16; i++) chk(rxQ[i], {i == 0, w[i]});
		chk(wrReady, 1);
		$display("t_fifo done");
	endtask

	task automatic t_recover();
		clr();
		reqRecover <= 1'b1;
		@(posedge mclk);
		reqRecover <= 1'b0;
		wait_idle();
		chk(rxQ.size(), 0);
		chk(standby, 1);
		chk(fe1, 0);
		$display("t_recover done");
	endtask

	task automatic put(input logic s, input logic d);
		link2.scl <= s;
		link2.nHostSdaOe <= d;
		repeat (4) @(posedge mclk);
	endtask

	task automatic send2(input tws_word_type v, input logic ackExp);
		for (int i = 7; i >= -1; i--) begin
			put(1'b0, i < 0 ? 1'b1 : v[i]);
			put(1'b1, i < 0 ? 1'b1 : v[i]);
			if (i < 0) chk(link2.sda, !ackExp);
			put(1'b0, i < 0 ? 1'b1 : v[i]);
		end
	endtask

	task automatic t_far_end();
		clr();
		send2(8'h42, 1'b0);
		chk(rx2Q.size(), 0);
		chk(ack2, 0);
		put(1'b1, 1'b1);
		put(1'b1, 1'b0);
		put(1'b0, 1'b0);
		send2(8'h42, 1'b1);
		put(1'b0, 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
		chk(rx2Q.size(), 1);
		chk(rx2Q[0], 8'h42);
		put(1'b1, 1'b0);
		for (int i = 0; i < 3; i++) put(i[0], 1'b0);
		put(1'b1, 1'b0);
		put(1'b1, 1'b1);
		chk(fe2, 1);
		$display("t_far_end done");
	endtask

	initial begin
		nrst = 1'b0;
		wrData = 8'h00;
		wrValid = 1'b0;
		reqGo = 1'b0;
		reqRead = 1'b0;
		reqCount = 8'h00;
		reqRecover = 1'b0;
		readData = rdTab[0];
		link2.scl = 1'b1;
		link2.nHostSdaOe = 1'b1;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		wait_idle();
		t_write();
		t_read();
		t_fifo();
		t_recover();
		t_far_end();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		end_of_test();
	end
endmodule // two_wire_serial_target_framing_tb
